// file: src/eeprom_read_host.sv
// Master end: issues reads and flag queries, buffers read bytes.
// Assumes the EEPROM end never stretches the link clock.
module eeprom_rd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Fill side
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    // Drain side
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] FULL = (PW + 1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr;
        logic [PW-1:0] rd;
        logic [PW:0] cnt;
    } fifo_state_t;

    fifo_state_t st;
    fifo_state_t next_st;
    logic push;
    logic pop;

    always_comb begin
        next_st = st;
        push = i_in_valid && st.cnt != FULL;
        pop = i_out_ready && st.cnt != '0;
        if (push) begin
            next_st.mem[st.wr] = i_in_data;
            next_st.wr = st.wr + 1'b1;
        end
        if (pop) begin
            next_st.rd = st.rd + 1'b1;
        end
        next_st.cnt = st.cnt + (PW + 1)'(push) - (PW + 1)'(pop);
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_in_ready = st.cnt != FULL;
    assign o_out_valid = st.cnt != '0;
    assign o_out_data = st.mem[st.rd];
endmodule : eeprom_rd_fifo

module eeprom_read_host import eeprom_pkg::*; (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Two-wire link
    eeprom_link_if.host link,
    // Target straps
    input wire logic i_strap_addr_hi,
    input wire logic i_strap_addr_mid,
    input wire logic i_strap_addr_lo,
    // Command
    input wire logic i_cmd_valid,
    input wire cmd_t i_cmd,
    input wire logic [7:0] i_word_addr,
    input wire logic [7:0] i_read_count,
    output logic o_cmd_ready,
    output logic o_done,
    output logic o_query_acked,
    // Read data
    output logic o_rd_valid,
    input wire logic i_rd_ready,
    output logic [7:0] o_rd_data
);
    typedef enum logic [3:0] {
        H_IDLE = 4'h1,
        H_START = 4'h2,
        H_BYTE = 4'h4,
        H_STOP = 4'h8
    } host_fsm_t;

    typedef enum logic [4:0] {
        S_DEVW = 5'h01,
        S_WORD = 5'h02,
        S_DEVR = 5'h04,
        S_DATA = 5'h08,
        S_QUERY = 5'h10
    } step_t;

    typedef struct packed {
        logic [2:0] sda_s;
        logic sda_f;
        host_fsm_t fsm;
        step_t step;
        logic [1:0] phase;
        logic [TICK_W-1:0] tick;
        logic [3:0] bit_cnt;
        logic [8:0] tx;
        logic [8:0] rx;
        logic [7:0] left;
        cmd_t cmd;
        logic [7:0] word;
        logic scl;
        logic sda_oe;
        logic ready;
        logic done;
        logic q_ack;
        logic push;
        logic [7:0] push_data;
    } host_state_t;

    host_state_t st;
    host_state_t next_st;
    logic [2:0] strap;
    logic fifo_ready;
    logic tick;

    assign strap = {i_strap_addr_hi, i_strap_addr_mid, i_strap_addr_lo};

    function automatic logic [8:0] load(step_t s, cmd_t c, logic [7:0] w,
                                        logic [7:0] n, logic [2:0] a);
        case (s)
            S_DEVW: load = {CTRL_CODE, a, 1'b0, 1'b1}; // R6
            S_WORD: load = {w, 1'b1};
            S_DEVR: load = {CTRL_CODE, a, 1'b1, 1'b1}; // R1 R7
            S_QUERY: load = (c == CMD_REV_QUERY) ?
                {QUERY_CODE, REV_QUERY_BITS, 1'b1, 1'b1} : // R13
                {QUERY_CODE, a, 1'b1, 1'b1}; // R11 R15
            default: load = {8'hFF, n == 8'h00}; // R5 R8
        endcase
    endfunction : load

    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        next_st.push = 1'b0;
        next_st.sda_s = {st.sda_s[1:0], link.sda};
        if (st.sda_s[1] == st.sda_s[2]) begin
            next_st.sda_f = st.sda_s[2];
        end
        tick = st.tick == TICK_LAST;
        // Hold the link clock while the buffer has no room
        if (!(st.fsm == H_BYTE && st.step == S_DATA && !fifo_ready)) begin
            next_st.tick = tick ? '0 : st.tick + 1'b1;
        end else begin
            tick = 1'b0;
        end
        if (tick) begin
            next_st.phase = st.phase + 2'h1;
        end
        case (st.fsm)
            H_IDLE: begin
                next_st.ready = 1'b1;
                next_st.tick = '0;
                if (i_cmd_valid) begin
                    next_st.ready = 1'b0;
                    next_st.q_ack = 1'b0;
                    next_st.cmd = i_cmd;
                    next_st.word = i_word_addr;
                    next_st.left = i_read_count;
                    next_st.phase = 2'h0;
                    next_st.fsm = H_START;
                    case (i_cmd)
                        CMD_CUR_READ: next_st.step = S_DEVR;
                        CMD_RAND_READ: next_st.step = S_DEVW;
                        default: next_st.step = S_QUERY;
                    endcase
                end
            end
            H_START: begin
                if (tick) begin
                    case (st.phase)
                        2'h0: next_st.scl = 1'b0;
                        2'h1: next_st.sda_oe = 1'b0;
                        2'h2: next_st.scl = 1'b1;
                        default: begin
                            next_st.sda_oe = 1'b1; // R1
                            next_st.fsm = H_BYTE;
                            next_st.bit_cnt = CNT_RESET;
                            next_st.tx = load(st.step, st.cmd, st.word,
                                              st.left, strap);
                        end
                    endcase
                end
            end
            H_BYTE: begin
                if (tick) begin
                    case (st.phase)
                        2'h0: next_st.scl = 1'b0;
                        2'h1: next_st.sda_oe = ~st.tx[8];
                        2'h2: next_st.scl = 1'b1;
                        default: begin
                            next_st.rx = {st.rx[7:0], st.sda_f};
                            next_st.tx = {st.tx[7:0], 1'b1};
                            next_st.bit_cnt = st.bit_cnt + CNT_FIRST;
                            if (st.bit_cnt == BITS_PER_BYTE) begin
                                next_st.bit_cnt = CNT_RESET;
                                next_st.fsm = H_STOP;
                                case (st.step)
                                    S_DEVW: begin
                                        if (!st.sda_f) begin
                                            next_st.step = S_WORD;
                                            next_st.fsm = H_BYTE;
                                        end
                                    end
                                    S_WORD: begin
                                        if (!st.sda_f) begin
                                            next_st.step = S_DEVR; // R7
                                            next_st.fsm = H_START;
                                        end
                                    end
                                    S_DEVR: begin
                                        if (!st.sda_f) begin
                                            next_st.step = S_DATA; // R4
                                            next_st.fsm = H_BYTE;
                                        end
                                    end
                                    S_DATA: begin
                                        next_st.push = 1'b1;
                                        next_st.push_data = st.rx[7:0];
                                        if (st.left != 8'h00) begin
                                            next_st.left = st.left - 8'h01;
                                            next_st.fsm = H_BYTE; // R8
                                        end
                                    end
                                    default: begin
                                        next_st.q_ack = ~st.sda_f; // R12 R14
                                    end
                                endcase
                                next_st.tx = load(next_st.step, st.cmd,
                                    st.word, next_st.left, strap);
                            end
                        end
                    endcase
                end
            end
            H_STOP: begin
                if (tick) begin
                    case (st.phase)
                        2'h0: next_st.scl = 1'b0;
                        2'h1: next_st.sda_oe = 1'b1;
                        2'h2: next_st.scl = 1'b1;
                        default: begin
                            next_st.sda_oe = 1'b0; // R5
                            next_st.fsm = H_IDLE;
                            next_st.done = 1'b1;
                            next_st.ready = 1'b1;
                        end
                    endcase
                end
            end
            default: begin
                next_st.fsm = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st <= '{
                sda_s: 3'h7, sda_f: 1'b1, fsm: H_IDLE, step: S_DEVR,
                phase: 2'h0, tick: '0, bit_cnt: CNT_RESET, tx: 9'h1FF,
                rx: 9'h000, left: 8'h00, cmd: CMD_CUR_READ, word: 8'h00,
                scl: 1'b1, sda_oe: 1'b0, ready: 1'b1, done: 1'b0,
                q_ack: 1'b0, push: 1'b0, push_data: 8'h00
            };
        end else begin
            st <= next_st;
        end
    end

    eeprom_rd_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) rd_fifo (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_in_valid(st.push),
        .o_in_ready(fifo_ready),
        .i_in_data(st.push_data),
        .o_out_valid(o_rd_valid),
        .i_out_ready(i_rd_ready),
        .o_out_data(o_rd_data)
    );

    assign link.scl = st.scl;
    assign link.host_sda_o = 1'b0;
    assign link.host_sda_oe = st.sda_oe;
    assign o_cmd_ready = st.ready;
    assign o_done = st.done;
    assign o_query_acked = st.q_ack;
endmodule : eeprom_read_host

// file: src/eeprom_pkg.sv
// Shared constants and types for the serial EEPROM read path.
// Assumes one 100 MHz clock; the master end makes the link clock.
// Function
// [R1] Read starts like write, direction bit one
// [R2] Word counter holds last address plus one
// [R3] Counter wraps from last byte to first
// [R4] After read address ack, shift out byte
// [R5] Master ends read with no ack, stop
// [R6] Dummy write loads word address into counter
// [R7] Repeated start, read address, data returned
// [R8] Master acks each byte to continue reading
// [R9] Device increments counter, sends next byte
// [R10] Sequential read wraps and keeps streaming
// [R11] Permanent flag query uses read direction
// [R12] Permanent query acked only when flag clear
// [R13] Reversible flag query uses read direction
// [R14] Reversible query acked only when flag set
// [R15] Permanent query byte 0110, straps, one
// [R16] Unacked query releases line, goes idle
package eeprom_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int LINK_PERIOD_NS = 160;
    localparam int QUARTER_CYC = LINK_PERIOD_NS / CLK_PERIOD_NS / 4;
    localparam int TICK_W = 3;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(QUARTER_CYC - 1);
    localparam int ADDR_W = 8;
    localparam int MEM_DEPTH = 256;
    localparam int FIFO_DEPTH = 16;
    localparam logic [3:0] CTRL_CODE = 4'hA;
    localparam logic [3:0] QUERY_CODE = 4'h6;
    localparam logic [2:0] REV_QUERY_BITS = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 8'h00;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] CNT_RESET = 4'h0;
    localparam logic [3:0] CNT_FIRST = 4'h1;

    typedef enum logic [3:0] {
        CMD_CUR_READ = 4'h1,
        CMD_RAND_READ = 4'h2,
        CMD_PERM_QUERY = 4'h4,
        CMD_REV_QUERY = 4'h8
    } cmd_t;
endpackage : eeprom_pkg

// file: src/eeprom_link_if.sv
// Two-wire link between the master end and the EEPROM end.
// Assumes open-drain data: a low from either end wins.
interface eeprom_link_if;
    logic scl;
    logic sda;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;

    // Wired-AND of both drivers with pull-up
    assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

    modport host (
        output scl,
        output host_sda_o,
        output host_sda_oe,
        input sda
    );

    modport dev (
        input scl,
        input sda,
        output dev_sda_o,
        output dev_sda_oe
    );
endinterface : eeprom_link_if

// file: src/eeprom_read_dev.sv
// EEPROM end: array read path, word counter and protect flag queries.
// Assumes the master drives the link clock; both pins are synchronised.
module eeprom_read_dev import eeprom_pkg::*; (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Two-wire link
    eeprom_link_if.dev link,
    // Address straps
    input wire logic i_strap_addr_hi,
    input wire logic i_strap_addr_mid,
    input wire logic i_strap_addr_lo,
    // Protect flags
    input wire logic i_permanent_protect_flag,
    input wire logic i_reversible_protect_flag,
    // Array fill port
    input wire logic i_fill_we,
    input wire logic [ADDR_W-1:0] i_fill_addr,
    input wire logic [7:0] i_fill_data,
    // Status
    output logic [ADDR_W-1:0] o_word_addr,
    output logic o_sda_driving
);

    typedef enum logic [7:0] {
        D_IDLE = 8'h01,
        D_ADDR = 8'h02,
        D_ACK_ADDR = 8'h04,
        D_WORD = 8'h08,
        D_ACK_WORD = 8'h10,
        D_SEND = 8'h20,
        D_RACK = 8'h40,
        D_ACK_QRY = 8'h80
    } dev_fsm_t;

    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic scl_f;
        logic sda_f;
        dev_fsm_t fsm;
        logic [3:0] bit_cnt;
        logic [7:0] shreg;
        logic [ADDR_W-1:0] addr;
        logic rw;
        logic sda_oe;
    } dev_state_t;

    dev_state_t st;
    dev_state_t next_st;
    logic [7:0] mem [MEM_DEPTH];
    logic [7:0] mem_word;
    logic [2:0] strap;
    logic [7:0] perm_byte;
    logic [7:0] rev_byte;
    logic scl_rise;
    logic scl_fall;
    logic scl_high;

    assign strap = {i_strap_addr_hi, i_strap_addr_mid, i_strap_addr_lo};
    assign perm_byte = {QUERY_CODE, strap, 1'b1}; // R15
    assign rev_byte = {QUERY_CODE, REV_QUERY_BITS, 1'b1};
    assign mem_word = mem[st.addr];

    // Array contents are loaded from the user side
    always_ff @(posedge i_clk) begin
        if (i_fill_we) begin
            mem[i_fill_addr] <= i_fill_data;
        end
    end

    always_comb begin
        next_st = st;
        next_st.scl_s = {st.scl_s[1:0], link.scl};
        next_st.sda_s = {st.sda_s[1:0], link.sda};
        if (st.scl_s[1] == st.scl_s[2]) begin
            next_st.scl_f = st.scl_s[2];
        end
        if (st.sda_s[1] == st.sda_s[2]) begin
            next_st.sda_f = st.sda_s[2];
        end
        scl_rise = next_st.scl_f & ~st.scl_f;
        scl_fall = ~next_st.scl_f & st.scl_f;
        scl_high = next_st.scl_f & st.scl_f;
        if (scl_high && next_st.sda_f && !st.sda_f) begin
            // Stop condition
            next_st.fsm = D_IDLE;
            next_st.sda_oe = 1'b0;
        end else if (scl_high && !next_st.sda_f && st.sda_f) begin
            // Start or repeated start
            next_st.fsm = D_ADDR; // R1
            next_st.bit_cnt = CNT_RESET;
            next_st.sda_oe = 1'b0;
        end else begin
            case (st.fsm)
                D_IDLE: begin
                    next_st.sda_oe = 1'b0;
                end
                D_ADDR, D_WORD: begin
                    if (scl_rise) begin
                        next_st.shreg = {st.shreg[6:0], next_st.sda_f};
                        next_st.bit_cnt = st.bit_cnt + CNT_FIRST;
                    end
                    if (scl_fall && st.bit_cnt == BITS_PER_BYTE) begin
                        if (st.fsm == D_WORD) begin
                            next_st.sda_oe = 1'b1; // R6
                            next_st.fsm = D_ACK_WORD;
                        end else if (st.shreg == {CTRL_CODE, strap,
                                                  st.shreg[0]}) begin
                            next_st.sda_oe = 1'b1; // R1
                            next_st.rw = st.shreg[0]; // R7
                            next_st.fsm = D_ACK_ADDR;
                        end else if (st.shreg == rev_byte) begin
                            // R13
                            if (i_reversible_protect_flag) begin
                                next_st.sda_oe = 1'b1; // R14
                                next_st.fsm = D_ACK_QRY;
                            end else begin
                                next_st.fsm = D_IDLE; // R16
                            end
                        end else if (st.shreg == perm_byte) begin
                            // R11
                            if (!i_permanent_protect_flag) begin
                                next_st.sda_oe = 1'b1; // R12
                                next_st.fsm = D_ACK_QRY;
                            end else begin
                                next_st.fsm = D_IDLE; // R16
                            end
                        end else begin
                            next_st.fsm = D_IDLE;
                        end
                    end
                end
                D_ACK_ADDR: begin
                    if (scl_fall) begin
                        next_st.sda_oe = 1'b0;
                        if (st.rw) begin
                            next_st.shreg = mem_word; // R4
                            next_st.sda_oe = ~mem_word[7];
                            next_st.addr = st.addr + 8'h01; // R2 R3 R10
                            next_st.bit_cnt = CNT_FIRST;
                            next_st.fsm = D_SEND;
                        end else begin
                            next_st.bit_cnt = CNT_RESET;
                            next_st.fsm = D_WORD; // R6
                        end
                    end
                end
                D_ACK_WORD: begin
                    if (scl_fall) begin
                        next_st.sda_oe = 1'b0;
                        next_st.addr = st.shreg; // R6
                        next_st.fsm = D_IDLE;
                    end
                end
                D_ACK_QRY: begin
                    if (scl_fall) begin
                        next_st.sda_oe = 1'b0;
                        next_st.fsm = D_IDLE;
                    end
                end
                D_SEND: begin
                    if (scl_fall) begin
                        if (st.bit_cnt == BITS_PER_BYTE) begin
                            next_st.sda_oe = 1'b0;
                            next_st.fsm = D_RACK;
                        end else begin
                            next_st.shreg = {st.shreg[6:0], 1'b0}; // R4
                            next_st.sda_oe = ~st.shreg[6];
                            next_st.bit_cnt = st.bit_cnt + CNT_FIRST;
                        end
                    end
                end
                D_RACK: begin
                    if (scl_rise) begin
                        if (!next_st.sda_f) begin
                            next_st.fsm = D_ACK_ADDR; // R8 R9 R10
                        end else begin
                            next_st.fsm = D_IDLE; // R5
                        end
                    end
                end
                default: begin
                    next_st.fsm = D_IDLE;
                    next_st.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st <= '{
                scl_s: 3'h7,
                sda_s: 3'h7,
                scl_f: 1'b1,
                sda_f: 1'b1,
                fsm: D_IDLE,
                bit_cnt: CNT_RESET,
                shreg: 8'h00,
                addr: ADDR_RESET,
                rw: 1'b0,
                sda_oe: 1'b0
            };
        end else begin
            st <= next_st;
        end
    end

    assign link.dev_sda_o = 1'b0;
    assign link.dev_sda_oe = st.sda_oe;
    assign o_word_addr = st.addr;
    assign o_sda_driving = st.sda_oe;

endmodule : eeprom_read_dev

// file: test/eeprom_link_sva.sv
// Checker on the two-wire link between master end and EEPROM end.
// Assumes the link clock flop toggles on 8-cycle halves.
module eeprom_link_sva (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Link signals
    input wire logic scl,
    input wire logic sda,
    input wire logic host_sda_o,
    input wire logic host_sda_oe,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);
    // Cycles since the link clock last moved
    logic [3:0] gap;
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            gap <= 4'hF;
        end else begin
            gap <= $changed(scl) ? 4'h0 : gap + 4'(gap != 4'hF);
        end
    end
    AST_RST_IDLE: assert property (disable iff (1'h0) i_sys_rst |=>
        scl && !host_sda_oe && !dev_sda_oe) else $error("link not idle");
    AST_PULL_ONLY: assert property (!host_sda_o && !dev_sda_o)
        else $error("data line driven high");
    AST_SCL_HALF: assert property ($changed(scl) |=> $stable(scl)[*7])
        else $error("link clock half period short");
    AST_START_HOST: assert property (scl && $past(scl) && $fell(sda) |->
        host_sda_oe && !dev_sda_oe) else $error("start not by master");
    AST_DEV_AFTER_FALL: assert property ($changed(dev_sda_oe) |->
        !scl && gap inside {[4'h1:4'h6]}) else $error("device edge late");
    AST_HOST_SETTLE: assert property ($changed(host_sda_oe) |->
        gap >= 4'h2) else $error("master data moves at clock edge");
    AST_DEV_HOLD: assert property ($rose(dev_sda_oe) |=> dev_sda_oe[*8])
        else $error("device bit too short");
    AST_ACK_SLOT: assert property ($rose(dev_sda_oe) |-> ##3
        !host_sda_oe) else $error("both ends drive data");
    AST_STOP_IDLE: assert property (scl && $past(scl) && $rose(sda) |=>
        (scl && sda)[*3]) else $error("line busy after stop");
    cover property ($rose(dev_sda_oe));
    cover property (scl && $past(scl) && $fell(sda));
    cover property (scl && $past(scl) && $rose(sda));
endmodule : eeprom_link_sva

// file: test/serial_eeprom_read_path_tb.sv
// Bench for master end and EEPROM end joined by the link interface.
// Assumes 100 MHz clock and the command contract of the master end.
module serial_eeprom_read_path_tb import eeprom_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 1'h0, i_sys_rst = 1'h1, vld = 1'h0, rdy = 1'h0;
    logic we = 1'h0, perm = 1'h0, rev = 1'h0, stall = 1'h0;
    logic scl_d = 1'h1, sda_d = 1'h1, c_rdy, done, qa, rv, sd;
    cmd_t cmd = CMD_CUR_READ;
    logic [7:0] wa = 8'h00, rc = 8'h00, fa = 8'h00, fd = 8'h00;
    logic [7:0] lfsr = 8'h3D, ctr = 8'h00, sh = 8'h00, rd, wad;
    logic [2:0] hs = 3'h4, ds = 3'h4;
    logic [7:0] mem [256];
    logic [7:0] exp_q [$], adr_q [$];
    int num_errors = 0, tests_run = 0, nb = 8;
    eeprom_link_if link ();
    eeprom_read_host eeprom_read_host_i (.i_clk(i_clk),
        .i_sys_rst(i_sys_rst), .link(link), .i_strap_addr_hi(hs[2]),
        .i_strap_addr_mid(hs[1]), .i_strap_addr_lo(hs[0]), .i_cmd_valid(vld),
        .i_cmd(cmd), .i_word_addr(wa), .i_read_count(rc), .o_cmd_ready(c_rdy),
        .o_done(done), .o_query_acked(qa), .o_rd_valid(rv), .i_rd_ready(rdy),
        .o_rd_data(rd));
    eeprom_read_dev eeprom_read_dev_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .link(link), .i_strap_addr_hi(ds[2]), .i_strap_addr_mid(ds[1]),
        .i_strap_addr_lo(ds[0]), .i_permanent_protect_flag(perm),
        .i_reversible_protect_flag(rev), .i_fill_we(we), .i_fill_addr(fa),
        .i_fill_data(fd), .o_word_addr(wad), .o_sda_driving(sd));
    eeprom_link_sva eeprom_link_sva_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .scl(link.scl), .sda(link.sda), .host_sda_o(link.host_sda_o),
        .host_sda_oe(link.host_sda_oe), .dev_sda_o(link.dev_sda_o),
        .dev_sda_oe(link.dev_sda_oe));
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_next
    task automatic check(input string nm, input logic [7:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic end_sim();
        if (num_errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim
    // Notes expected address bytes and read data, then runs one command
    task automatic run_cmd(input cmd_t c, input logic [7:0] a, n);
        int k;
        logic [7:0] s;
        s = (c == CMD_RAND_READ) ? a : ctr;
        if (c == CMD_RAND_READ) adr_q.push_back({CTRL_CODE, hs, 1'h0});
        if (c != CMD_PERM_QUERY && c != CMD_REV_QUERY) begin
            adr_q.push_back({CTRL_CODE, hs, 1'h1});
        end
        if (c == CMD_PERM_QUERY) adr_q.push_back({QUERY_CODE, hs, 1'h1});
        if (c == CMD_REV_QUERY) adr_q.push_back({QUERY_CODE, 4'h3});
        if (c inside {CMD_CUR_READ, CMD_RAND_READ} && hs == ds) begin
            for (k = 0; k <= n; k++) exp_q.push_back(mem[8'(s + k)]);
            ctr = 8'(s + n + 1);
        end
        @(posedge i_clk);
        #1 vld = 1'h1;
        cmd = c;
        wa = a;
        rc = n;
        @(posedge i_clk);
        #1 vld = 1'h0;
        for (k = 0; done !== 1'h1 && k < 20000; k++) begin
            @(posedge i_clk);
            #1;
        end
        if (done !== 1'h1) num_errors++;
        check("word_addr", wad, ctr);
    endtask : run_cmd
    initial begin
        forever #5 i_clk = ~i_clk;
    end
    initial begin
        forever begin
            @(posedge i_clk);
            #1 rdy = !stall && lfsr[0];
            lfsr = lfsr_next(lfsr);
        end
    end
    // Read data at the buffer output and address bytes seen on the wire
    always @(negedge i_clk) begin
        if (rv === 1'h1 && rdy) begin
            check("rd_data", rd, exp_q.size() ? exp_q.pop_front() : 8'hXX);
        end
        if (link.scl && scl_d && sda_d && !link.sda) begin
            nb = 0;
        end else if (link.scl && !scl_d && nb < 8) begin
            sh = {sh[6:0], link.sda};
            nb++;
            if (nb == 8) check("adr", sh, adr_q.pop_front());
        end
        scl_d = link.scl;
        sda_d = link.sda;
    end
    initial begin
        repeat (60000) @(posedge i_clk);
        num_errors++;
        end_sim();
    end
    initial begin
        int i;
        repeat (3) @(posedge i_clk);
        #1 i_sys_rst = 1'h0;
        ds = {1'h1, lfsr[1:0]};
        hs = ds;
        for (i = 0; i < 256; i++) begin
            @(posedge i_clk);
            #1 we = 1'h1;
            fa = 8'(i);
            fd = lfsr;
            mem[i] = lfsr;
        end
        @(posedge i_clk);
        #1 we = 1'h0;
        run_cmd(CMD_RAND_READ, 8'hFE, 8'h03);
        run_cmd(CMD_CUR_READ, 8'h00, 8'h00);
        hs = ds ^ 3'h2;
        run_cmd(CMD_CUR_READ, 8'h00, 8'h00);
        hs = ds;
        stall = 1'h1;
        fork
            run_cmd(CMD_CUR_READ, 8'h00, 8'h13);
            begin
                repeat (4000) @(posedge i_clk);
                #1 stall = 1'h0;
            end
        join
        for (i = 0; i < 4; i++) begin
            perm = i[0];
            rev = i[1];
            run_cmd(CMD_PERM_QUERY, 8'h00, 8'h00);
            check("perm_ack", {7'h0, qa}, {7'h0, !perm});
            run_cmd(CMD_REV_QUERY, 8'h00, 8'h00);
            check("rev_ack", {7'h0, qa}, {7'h0, rev});
        end
        repeat (200) @(posedge i_clk);
        check("left", 8'(exp_q.size() + adr_q.size()), 8'h00);
        check("dev_drive", {7'h0, sd}, 8'h00);
        end_sim();
    end
endmodule : serial_eeprom_read_path_tb
